// ==== core/flash_erase_write_controller.v ====
// Flash erase/write sequencer with timing generator, locks and CPU hold
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "flash_ctl_regs.vh"
module flash_erase_write_controller
#(
   parameter [15:0] ERASE_TICKS = `ERASE_TICKS,
   parameter [15:0] FAIL_CYC = `FAIL_CYC
)
(
   input wire clk_sys_i,
   input wire resetn_i,
   input wire [1:0] reg_addr_i,
   input wire [15:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [15:0] reg_rdata_o,
   input wire [9:0] fl_addr_i,
   input wire [15:0] fl_wdata_i,
   input wire [1:0] fl_byte_en_i,
   input wire fl_wr_i,
   input wire fl_rd_i,
   input wire fl_fetch_i,
   input wire fl_from_flash_i,
   output reg [15:0] fl_rdata_o,
   output reg cpu_hold_o,
   input wire aux_clock_i,
   input wire sub_main_clock_i,
   input wire main_clock_i,
   input wire lp_req_i,
   output reg sel_clock_run_o,
   output reg timing_gen_on_o,
   output reg prog_voltage_o,
   output reg busy_o
);
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_ERASE = 3'h1;
   localparam [2:0] ST_WRITE = 3'h2;
   localparam [2:0] ST_RMW_RD = 3'h3;
   localparam [2:0] ST_RMW_WAIT = 3'h4;
   localparam [2:0] ST_COMMIT = 3'h5;
   localparam [2:0] ST_BLK_WAIT = 3'h6;

   reg [2:0] state_q;
   reg erase_sel_q;
   reg mass_erase_select_q;
   reg write_select_q;
   reg block_write_select_q;
   reg [5:0] timing_clock_divider_q;
   reg [1:0] clk_src_q;
   reg first_info_segment_lock_q;
   reg access_violation_flag_q;
   reg fail_q;
   reg from_flash_q;
   reg [9:0] ptr_q;
   reg [9:0] hi_q;
   reg [15:0] data_q;
   reg [15:0] tick_q;
   reg [5:0] div_cnt_q;
   reg [15:0] idle_clk_q;
   reg subst_q;
   reg [2:0] aux_sync_q;
   reg [2:0] sub_sync_q;
   reg [2:0] main_sync_q;

   wire [15:0] mem_rdata;
   reg mem_we;
   reg [9:0] mem_waddr;
   reg [15:0] mem_wdata;
   reg [9:0] mem_raddr;
   reg sel_edge;
   reg ftg_tick;
   reg in_erase_range;
   reg [9:0] erase_lo;
   reg [9:0] erase_hi;
   wire busy_w;
   wire addr_ok;
   wire cpu_touch;

   // Word address inside the first info segment
   function in_seg_a;
      input [9:0] a;
      begin
         in_seg_a = (a <= `SEG_A_HI);
      end
   endfunction

   // Lowest word of the segment holding a word address
   function [9:0] seg_base;
      input [9:0] a;
      begin
         if (a < `MAIN_LO)
         begin
            seg_base = a & `INFO_SEG_MASK;
         end
         else
         begin
            seg_base = ((a - `MAIN_LO) & `MAIN_SEG_MASK) + `MAIN_LO;
         end
      end
   endfunction

   assign busy_w = (state_q != ST_IDLE);
   assign addr_ok = (fl_addr_i < `FLASH_WORDS);
   assign cpu_touch = fl_wr_i | fl_rd_i | fl_fetch_i;

   // info segments 32 words, main 256 words
   always @*
   begin
      erase_lo = `MAIN_LO;
      erase_hi = `FLASH_WORDS - 10'h001;
      in_erase_range = 1'b0;
      if (!mass_erase_select_q && erase_sel_q)
      begin
         erase_lo = seg_base(fl_addr_i);
         if (fl_addr_i < `MAIN_LO)
         begin
            erase_hi = erase_lo + 10'h01F;
         end
         else
         begin
            erase_hi = erase_lo + 10'h0FF;
         end
         in_erase_range = addr_ok && !(first_info_segment_lock_q && in_seg_a(fl_addr_i));
      end
      else if (mass_erase_select_q && !erase_sel_q)
      begin
         in_erase_range = addr_ok && (fl_addr_i >= `MAIN_LO);
      end
      else if (mass_erase_select_q && erase_sel_q)
      begin
         // lock keeps info memory out of all-erase
         if (!first_info_segment_lock_q)
         begin
            erase_lo = `INFO_LO;
            in_erase_range = addr_ok;
         end
         else
         begin
            in_erase_range = addr_ok && (fl_addr_i >= `MAIN_LO);
         end
      end
   end

   // source select on synchronised clock edges
   always @*
   begin
      case (clk_src_q)
         `SRC_AUX: sel_edge = aux_sync_q[1] & ~aux_sync_q[2];
         `SRC_SUB_MAIN: sel_edge = sub_sync_q[1] & ~sub_sync_q[2];
         default: sel_edge = main_sync_q[1] & ~main_sync_q[2];
      endcase
      ftg_tick = busy_w && sel_edge && (div_cnt_q == timing_clock_divider_q);
   end

   // erase writes ones, program ANDs into old word
   always @*
   begin
      mem_we = 1'b0;
      mem_waddr = ptr_q;
      mem_wdata = `ERASED_WORD;
      mem_raddr = fl_addr_i;
      if (state_q == ST_ERASE && ptr_q <= hi_q)
      begin
         mem_we = 1'b1;
      end
      if (state_q == ST_RMW_RD || state_q == ST_RMW_WAIT)
      begin
         mem_raddr = ptr_q;
      end
      if (state_q == ST_COMMIT)
      begin
         mem_we = 1'b1;
         mem_wdata = mem_rdata & data_q;
      end
   end

   flash_word_array u_array
   (
      .clk_sys_i(clk_sys_i),
      .we_i(mem_we),
      .waddr_i(mem_waddr),
      .wdata_i(mem_wdata),
      .raddr_i(mem_raddr),
      .rdata_o(mem_rdata)
   );

   always @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         aux_sync_q <= 3'h0;
         sub_sync_q <= 3'h0;
         main_sync_q <= 3'h0;
         div_cnt_q <= 6'h00;
         idle_clk_q <= 16'h0000;
      end
      else
      begin
         aux_sync_q <= {aux_sync_q[1:0], aux_clock_i};
         sub_sync_q <= {sub_sync_q[1:0], sub_main_clock_i};
         main_sync_q <= {main_sync_q[1:0], main_clock_i};
         if (!busy_w || ftg_tick)
         begin
            div_cnt_q <= 6'h00;
         end
         else if (sel_edge)
         begin
            div_cnt_q <= div_cnt_q + 6'h01;
         end
         if (!busy_w || sel_edge)
         begin
            idle_clk_q <= 16'h0000;
         end
         else if (idle_clk_q != FAIL_CYC)
         begin
            idle_clk_q <= idle_clk_q + 16'h0001;
         end
      end
   end

   always @(posedge clk_sys_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         state_q <= ST_IDLE;
         erase_sel_q <= 1'b0;
         mass_erase_select_q <= 1'b0;
         write_select_q <= 1'b0;
         block_write_select_q <= 1'b0;
         timing_clock_divider_q <= 6'h00;
         clk_src_q <= 2'h0;
         first_info_segment_lock_q <= `FIRST_INFO_SEGMENT_LOCK_RST;
         access_violation_flag_q <= 1'b0;
         fail_q <= 1'b0;
         from_flash_q <= 1'b0;
         ptr_q <= 10'h000;
         hi_q <= 10'h000;
         data_q <= 16'h0000;
         tick_q <= 16'h0000;
         subst_q <= 1'b0;
         reg_rdata_o <= 16'h0000;
         fl_rdata_o <= 16'h0000;
         cpu_hold_o <= 1'b0;
         sel_clock_run_o <= 1'b1;
         timing_gen_on_o <= 1'b0;
         prog_voltage_o <= 1'b0;
         busy_o <= 1'b0;
      end
      else
      begin
         if (reg_wr_i && reg_addr_i == `REG_MODE_IDX && (!busy_w || state_q == ST_BLK_WAIT))
         begin
            erase_sel_q <= reg_wdata_i[`MODE_ERASE_BIT];
            mass_erase_select_q <= reg_wdata_i[`MODE_MASS_BIT];
            write_select_q <= reg_wdata_i[`MODE_WRITE_BIT];
            block_write_select_q <= reg_wdata_i[`MODE_BLOCK_BIT];
         end
         if (reg_wr_i && reg_addr_i == `REG_CLK_IDX && !busy_w)
         begin
            timing_clock_divider_q <= reg_wdata_i[`CLK_DIV_MSB:`CLK_DIV_LSB];
            clk_src_q <= reg_wdata_i[`CLK_SEL_MSB:`CLK_SEL_LSB];
         end
         if (reg_wr_i && reg_addr_i == `REG_STAT_IDX)
         begin
            // one toggles the lock, zero keeps it
            if (reg_wdata_i[`STAT_FIRST_INFO_SEGMENT_LOCK_BIT])
            begin
               first_info_segment_lock_q <= ~first_info_segment_lock_q;
            end
            if (!reg_wdata_i[`STAT_ACCV_BIT])
            begin
               access_violation_flag_q <= 1'b0;
            end
            if (!reg_wdata_i[`STAT_FAIL_BIT])
            begin
               fail_q <= 1'b0;
            end
         end
         if (reg_rd_i)
         begin
            reg_rdata_o <= 16'h0000;
            case (reg_addr_i)
               `REG_MODE_IDX:
               begin
                  reg_rdata_o[`MODE_ERASE_BIT] <= erase_sel_q;
                  reg_rdata_o[`MODE_MASS_BIT] <= mass_erase_select_q;
                  reg_rdata_o[`MODE_WRITE_BIT] <= write_select_q;
                  reg_rdata_o[`MODE_BLOCK_BIT] <= block_write_select_q;
               end
               `REG_CLK_IDX:
               begin
                  reg_rdata_o[`CLK_DIV_MSB:`CLK_DIV_LSB] <= timing_clock_divider_q;
                  reg_rdata_o[`CLK_SEL_MSB:`CLK_SEL_LSB] <= clk_src_q;
               end
               `REG_STAT_IDX:
               begin
                  reg_rdata_o[`STAT_BUSY_BIT] <= busy_w;
                  reg_rdata_o[`STAT_ACCV_BIT] <= access_violation_flag_q;
                  reg_rdata_o[`STAT_WAIT_BIT] <= (state_q == ST_BLK_WAIT);
                  reg_rdata_o[`STAT_FIRST_INFO_SEGMENT_LOCK_BIT] <= first_info_segment_lock_q;
                  reg_rdata_o[`STAT_FAIL_BIT] <= fail_q;
               end
               default: reg_rdata_o <= 16'h0000;
            endcase
         end
         if (ftg_tick)
         begin
            tick_q <= tick_q + 16'h0001;
         end
         case (state_q)
            ST_IDLE:
            begin
               tick_q <= 16'h0000;
               if (fl_wr_i && addr_ok)
               begin
                  if (erase_sel_q || mass_erase_select_q)
                  begin
                     if (in_erase_range)
                     begin
                        state_q <= ST_ERASE;
                        ptr_q <= erase_lo;
                        hi_q <= erase_hi;
                        from_flash_q <= fl_from_flash_i;
                     end
                  end
                  // write select starts byte/word or block write
                  else if (write_select_q)
                  begin
                     if (!(first_info_segment_lock_q && in_seg_a(fl_addr_i)))
                     begin
                        state_q <= ST_WRITE;
                        ptr_q <= fl_addr_i;
                        data_q <= {fl_byte_en_i[1] ? fl_wdata_i[15:8] : 8'hFF,
                                   fl_byte_en_i[0] ? fl_wdata_i[7:0] : 8'hFF};
                        from_flash_q <= fl_from_flash_i & ~block_write_select_q;
                     end
                  end
                  else
                  begin
                     access_violation_flag_q <= 1'b1;
                  end
               end
            end
            ST_ERASE:
            begin
               if (ptr_q <= hi_q)
               begin
                  ptr_q <= ptr_q + 10'h001;
               end
               // erase end clears busy and erase selects
               if (tick_q >= ERASE_TICKS && ptr_q > hi_q)
               begin
                  state_q <= ST_IDLE;
                  erase_sel_q <= 1'b0;
                  mass_erase_select_q <= 1'b0;
               end
            end
            ST_WRITE:
            begin
               if (tick_q == {11'h000, `WRITE_TICKS})
               begin
                  state_q <= ST_RMW_RD;
               end
            end
            ST_RMW_RD: state_q <= ST_RMW_WAIT;
            ST_RMW_WAIT: state_q <= ST_COMMIT;
            ST_COMMIT:
            begin
               tick_q <= 16'h0000;
               state_q <= block_write_select_q ? ST_BLK_WAIT : ST_IDLE;
            end
            ST_BLK_WAIT:
            begin
               tick_q <= 16'h0000;
               if (!block_write_select_q)
               begin
                  state_q <= ST_IDLE;
               end
               else if (fl_wr_i && addr_ok && !(first_info_segment_lock_q && in_seg_a(fl_addr_i)))
               begin
                  state_q <= ST_WRITE;
                  ptr_q <= fl_addr_i;
                  data_q <= {fl_byte_en_i[1] ? fl_wdata_i[15:8] : 8'hFF,
                             fl_byte_en_i[0] ? fl_wdata_i[7:0] : 8'hFF};
               end
            end
            default: state_q <= ST_IDLE;
         endcase
         if (busy_w && state_q != ST_BLK_WAIT && !from_flash_q && cpu_touch)
         begin
            access_violation_flag_q <= 1'b1;
         end
         if (state_q == ST_BLK_WAIT && (fl_rd_i || fl_fetch_i))
         begin
            access_violation_flag_q <= 1'b1;
         end
         // abort returns to idle so busy drops, and clears all selects
         if (busy_w && idle_clk_q == FAIL_CYC)
         begin
            fail_q <= 1'b1;
            state_q <= ST_IDLE;
            erase_sel_q <= 1'b0;
            mass_erase_select_q <= 1'b0;
            write_select_q <= 1'b0;
            block_write_select_q <= 1'b0;
         end
         subst_q <= fl_fetch_i && busy_w && from_flash_q;
         fl_rdata_o <= subst_q ? `JMP_SELF : mem_rdata;
         // hold CPU for erase started from flash
         // hold CPU for byte/word write started from flash, not for block write
         cpu_hold_o <= busy_w && from_flash_q && idle_clk_q != FAIL_CYC;
         busy_o <= busy_w && idle_clk_q != FAIL_CYC;
         timing_gen_on_o <= busy_w && idle_clk_q != FAIL_CYC;
         // keep selected clock running while busy
         sel_clock_run_o <= !lp_req_i || busy_w;
         // voltage on for first 27 of 30 ticks of byte/word write, throughout erase and block write
         prog_voltage_o <= (state_q == ST_WRITE && tick_q < {11'h000, `VOLT_TICKS})
                           || (state_q == ST_ERASE)
                           || (block_write_select_q && busy_w && state_q != ST_ERASE);
      end
   end
endmodule // flash_erase_write_controller

// ==== core/flash_ctl_regs.vh ====
// Register offsets, field positions, reset values and timing counts of the flash controller
`ifndef FLASH_CTL_REGS_VH
`define FLASH_CTL_REGS_VH
`define REG_MODE_IDX 2'h0
`define REG_CLK_IDX 2'h1
`define REG_STAT_IDX 2'h2
`define MODE_ERASE_BIT 1
`define MODE_MASS_BIT 2
`define MODE_WRITE_BIT 6
`define MODE_BLOCK_BIT 7
`define MODE_RST 4'h0
`define CLK_DIV_LSB 0
`define CLK_DIV_MSB 5
`define CLK_SEL_LSB 6
`define CLK_SEL_MSB 7
`define CLK_RST 8'h00
`define SRC_AUX 2'h0
`define SRC_SUB_MAIN 2'h1
`define STAT_BUSY_BIT 0
`define STAT_ACCV_BIT 2
`define STAT_WAIT_BIT 3
`define STAT_FIRST_INFO_SEGMENT_LOCK_BIT 6
`define STAT_FAIL_BIT 7
`define FIRST_INFO_SEGMENT_LOCK_RST 1'b1
`define INFO_LO 10'h000
`define MAIN_LO 10'h080
`define FLASH_WORDS 10'h280
`define SEG_A_HI 10'h01F
`define INFO_SEG_MASK 10'h3E0
`define MAIN_SEG_MASK 10'h300
`define WRITE_TICKS 5'h1E
`define VOLT_TICKS 5'h1B
`define ERASE_TICKS 16'h0100
`define FAIL_CYC 16'h0400
`define JMP_SELF 16'h3FFF
`define ERASED_WORD 16'hFFFF
`endif

// ==== core/flash_word_array.v ====
// Flash word array with registered read port
`timescale 1ns/1ps
module flash_word_array
(
   input wire clk_sys_i,
   input wire we_i,
   input wire [9:0] waddr_i,
   input wire [15:0] wdata_i,
   input wire [9:0] raddr_i,
   output reg [15:0] rdata_o
);
   reg [15:0] mem [0:639];

   always @(posedge clk_sys_i)
   begin
      if (we_i)
      begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end
endmodule // flash_word_array

// ==== verification/flash_ctl_assertions.sv ====
// Port-level checks of the flash erase/write controller
`timescale 1ns/1ps
module flash_ctl_checker
(
   input wire clk_sys_i,
   input wire resetn_i,
   input wire fl_wr_i,
   input wire fl_fetch_i,
   input wire fl_from_flash_i,
   input wire [15:0] fl_rdata_o,
   input wire cpu_hold_o,
   input wire sel_clock_run_o,
   input wire timing_gen_on_o,
   input wire prog_voltage_o,
   input wire busy_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!resetn_i);
   a_busy_cause: assert property ($rose(busy_o) |-> $past(fl_wr_i, 2))
      else $error("busy rose without a flash write");
   a_busy_holds: assert property ($rose(busy_o) |-> busy_o [*8])
      else $error("busy dropped too early");
   a_idle_quiet: assert property (!busy_o && !$past(busy_o) && !$past(busy_o, 2)
      |-> !timing_gen_on_o && !prog_voltage_o)
      else $error("generators on while idle");
   a_gen_busy: assert property ($rose(timing_gen_on_o) |-> busy_o)
      else $error("timing generator started while idle");
   a_hold_cause: assert property ($rose(cpu_hold_o) |-> busy_o && $past(fl_from_flash_i, 2))
      else $error("hold without an op from flash");
   a_ram_no_hold: assert property ($rose(busy_o) && !$past(fl_from_flash_i, 2)
      |-> !cpu_hold_o)
      else $error("hold for an op from ram");
   a_clock_kept: assert property (busy_o && $past(busy_o) |-> sel_clock_run_o)
      else $error("selected clock stopped while busy");
   a_fetch_jump: assert property ((cpu_hold_o && fl_fetch_i) ##1 cpu_hold_o
      |-> ##1 fl_rdata_o == 16'h3FFF)
      else $error("fetch under hold gave no jump opcode");
endmodule // flash_ctl_checker
bind flash_erase_write_controller flash_ctl_checker flash_ctl_checker_i
(
   .clk_sys_i(clk_sys_i),
   .resetn_i(resetn_i),
   .fl_wr_i(fl_wr_i),
   .fl_fetch_i(fl_fetch_i),
   .fl_from_flash_i(fl_from_flash_i),
   .fl_rdata_o(fl_rdata_o),
   .cpu_hold_o(cpu_hold_o),
   .sel_clock_run_o(sel_clock_run_o),
   .timing_gen_on_o(timing_gen_on_o),
   .prog_voltage_o(prog_voltage_o),
   .busy_o(busy_o)
);

// ==== verification/src_clock_model.sv ====
// Source clock model standing in for the system clock tree
`timescale 1ns/1ps
module src_clock_model
(
   input wire stop_i,
   output logic aux_clock_o,
   output logic sub_main_clock_o,
   output logic main_clock_o
);
   initial
   begin
      aux_clock_o = 1'b0;
      sub_main_clock_o = 1'b0;
      main_clock_o = 1'b0;
   end
   always #102 if (!stop_i) aux_clock_o = ~aux_clock_o;
   always #42 if (!stop_i) sub_main_clock_o = ~sub_main_clock_o;
   always #16 if (!stop_i) main_clock_o = ~main_clock_o;
endmodule // src_clock_model

// ==== verification/tb_flash_erase_write_controller.sv ====
// Self-checking bench for the flash erase/write controller
`timescale 1ns/1ps
module tb_flash_erase_write_controller;
   logic clk_sys_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [1:0] reg_addr_i = 2'h0;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [9:0] fl_addr_i = 10'h000;
   logic [15:0] fl_wdata_i = 16'h0000;
   logic [1:0] fl_byte_en_i = 2'h3;
   logic fl_wr_i = 1'b0;
   logic fl_rd_i = 1'b0;
   logic fl_fetch_i = 1'b0;
   logic fl_from_flash_i = 1'b0;
   logic lp_req_i = 1'b0;
   logic stop = 1'b0;
   wire [15:0] reg_rdata_o;
   wire [15:0] fl_rdata_o;
   wire aux_clk, sub_clk, main_clk;
   wire cpu_hold_o, sel_clock_run_o, timing_gen_on_o, prog_voltage_o, busy_o;
   int n_errors = 0;
   int cmp_count = 0;
   int n_busy;
   int n_volt;
   int i;
   int tk[3] = '{32, 168, 204};
   logic [15:0] cw[3] = '{16'h0080, 16'h0041, 16'h0000};
   logic [9:0] a;

   always #4 clk_sys_i = ~clk_sys_i;

   src_clock_model src_clock_model_i (.stop_i(stop), .aux_clock_o(aux_clk),
      .sub_main_clock_o(sub_clk), .main_clock_o(main_clk));

   flash_erase_write_controller #(.ERASE_TICKS(16'h0004), .FAIL_CYC(16'h0040))
      flash_erase_write_controller_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .fl_addr_i(fl_addr_i),
      .fl_wdata_i(fl_wdata_i), .fl_byte_en_i(fl_byte_en_i), .fl_wr_i(fl_wr_i),
      .fl_rd_i(fl_rd_i), .fl_fetch_i(fl_fetch_i), .fl_from_flash_i(fl_from_flash_i),
      .fl_rdata_o(fl_rdata_o), .cpu_hold_o(cpu_hold_o), .aux_clock_i(aux_clk),
      .sub_main_clock_i(sub_clk), .main_clock_i(main_clk), .lp_req_i(lp_req_i),
      .sel_clock_run_o(sel_clock_run_o), .timing_gen_on_o(timing_gen_on_o),
      .prog_voltage_o(prog_voltage_o), .busy_o(busy_o));

   task chk(input string nm, input [15:0] e, input [15:0] g);
      cmp_count++;
      if (g !== e)
      begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask

   task wr(input [1:0] ad, input [15:0] d);
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= ad;
      reg_wdata_i <= d;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
   endtask

   task rdc(input [1:0] ad, input [15:0] m, input [15:0] e, input string nm);
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= ad;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      #1;
      chk(nm, e, reg_rdata_o & m);
   endtask

   // Flash write; returns once busy is visible
   task fw(input [9:0] ad, input [15:0] d, input [1:0] be, input ff);
      @(posedge clk_sys_i);
      fl_wr_i <= 1'b1;
      fl_addr_i <= ad;
      fl_wdata_i <= d;
      fl_byte_en_i <= be;
      fl_from_flash_i <= ff;
      @(posedge clk_sys_i);
      fl_wr_i <= 1'b0;
      @(posedge clk_sys_i);
      #1;
   endtask

   task frc(input [9:0] ad, input ft, input [15:0] e, input string nm);
      @(posedge clk_sys_i);
      fl_fetch_i <= ft;
      fl_rd_i <= !ft;
      fl_addr_i <= ad;
      @(posedge clk_sys_i);
      fl_fetch_i <= 1'b0;
      fl_rd_i <= 1'b0;
      @(posedge clk_sys_i);
      #1;
      chk(nm, e, fl_rdata_o);
   endtask

   task wait_idle;
      n_busy = 0;
      n_volt = 0;
      while (busy_o === 1'b1 && n_busy < 4000)
      begin
         @(posedge clk_sys_i);
         #1;
         n_busy++;
         if (prog_voltage_o === 1'b1)
            n_volt++;
      end
      chk("busy end", 16'h0000, {15'h0, busy_o});
   endtask

   task tally_and_finish;
      if (n_errors == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      repeat (30000) @(posedge clk_sys_i);
      n_errors++;
      tally_and_finish();
   end

   initial
   begin
      repeat (6) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      #1;
      chk("busy", 16'h0000, {15'h0, busy_o});
      chk("clock run", 16'h0001, {15'h0, sel_clock_run_o});
      rdc(2'h2, 16'h00CD, 16'h0040, "status");
      rdc(2'h0, 16'h00C6, 16'h0000, "mode");
      rdc(2'h3, 16'hFFFF, 16'h0000, "spare reg");
      wr(2'h1, 16'h0080);
      fw(10'h100, 16'h0000, 2'h3, 1'b0);
      chk("busy", 16'h0000, {15'h0, busy_o});
      rdc(2'h2, 16'h0004, 16'h0004, "violation");
      wr(2'h2, 16'h0040);
      rdc(2'h2, 16'h0044, 16'h0000, "lock");
      wr(2'h2, 16'h0000);
      rdc(2'h2, 16'h0040, 16'h0000, "lock");
      wr(2'h0, 16'h0006);
      fw(10'h000, 16'h0000, 2'h3, 1'b0);
      chk("busy", 16'h0001, {15'h0, busy_o});
      wait_idle();
      rdc(2'h0, 16'h00C6, 16'h0000, "mode");
      frc(10'h005, 1'b0, 16'hFFFF, "info word");
      frc(10'h27F, 1'b0, 16'hFFFF, "main word");
      wr(2'h2, 16'h0040);
      rdc(2'h2, 16'h0040, 16'h0040, "lock");
      wr(2'h0, 16'h0040);
      fw(10'h005, 16'h0000, 2'h3, 1'b0);
      chk("busy", 16'h0000, {15'h0, busy_o});
      frc(10'h005, 1'b0, 16'hFFFF, "locked word");
      fw(10'h040, 16'h0000, 2'h3, 1'b0);
      wait_idle();
      frc(10'h040, 1'b0, 16'h0000, "info word");
      for (i = 0; i < 3; i++)
      begin
         a = 10'h100 + 10'(i);
         wr(2'h1, cw[i]);
         fw(a, 16'h0123, 2'h3, 1'b0);
         wait_idle();
         chk("volt", 16'h1, {15'h0, n_volt * 8 >= 26 * tk[i] && n_volt * 8 <= 28 * tk[i]});
         chk("busy", 16'h1, {15'h0, n_busy * 8 >= 29 * tk[i] && n_busy * 8 <= 31 * tk[i] + 80});
         frc(a, 1'b0, 16'h0123, "word");
      end
      wr(2'h1, 16'h0080);
      fw(10'h100, 16'h00F0, 2'h1, 1'b0);
      wait_idle();
      frc(10'h100, 1'b0, 16'h0120, "anded word");
      wr(2'h0, 16'h0006);
      fw(10'h080, 16'h0000, 2'h3, 1'b0);
      wait_idle();
      frc(10'h040, 1'b0, 16'h0000, "spared info");
      frc(10'h100, 1'b0, 16'hFFFF, "erased main");
      wr(2'h0, 16'h0004);
      fw(10'h040, 16'h0000, 2'h3, 1'b0);
      chk("busy", 16'h0000, {15'h0, busy_o});
      rdc(2'h2, 16'h0004, 16'h0000, "violation");
      fw(10'h200, 16'h0000, 2'h3, 1'b0);
      chk("busy", 16'h0001, {15'h0, busy_o});
      wait_idle();
      frc(10'h040, 1'b0, 16'h0000, "info word");
      lp_req_i <= 1'b1;
      wr(2'h0, 16'h0040);
      fw(10'h101, 16'h0F0F, 2'h3, 1'b1);
      chk("hold", 16'h0001, {15'h0, cpu_hold_o});
      frc(10'h101, 1'b1, 16'h3FFF, "fetch");
      chk("clock run", 16'h0001, {15'h0, sel_clock_run_o});
      wait_idle();
      frc(10'h101, 1'b1, 16'h0F0F, "fetch");
      chk("hold", 16'h0000, {15'h0, cpu_hold_o});
      chk("clock run", 16'h0000, {15'h0, sel_clock_run_o});
      lp_req_i <= 1'b0;
      wr(2'h0, 16'h0002);
      fw(10'h100, 16'h0000, 2'h3, 1'b1);
      chk("hold", 16'h0001, {15'h0, cpu_hold_o});
      frc(10'h100, 1'b1, 16'h3FFF, "fetch");
      wait_idle();
      frc(10'h100, 1'b1, 16'hFFFF, "fetch");
      wr(2'h0, 16'h0002);
      fw(10'h200, 16'h0000, 2'h3, 1'b0);
      chk("hold", 16'h0000, {15'h0, cpu_hold_o});
      @(posedge clk_sys_i);
      fl_rd_i <= 1'b1;
      @(posedge clk_sys_i);
      fl_rd_i <= 1'b0;
      wait_idle();
      rdc(2'h2, 16'h0004, 16'h0004, "violation");
      wr(2'h2, 16'h0000);
      wr(2'h0, 16'h00C0);
      fw(10'h103, 16'h1111, 2'h3, 1'b0);
      repeat (200) @(posedge clk_sys_i);
      rdc(2'h2, 16'h000D, 16'h0009, "wait");
      fw(10'h104, 16'h2222, 2'h3, 1'b0);
      repeat (200) @(posedge clk_sys_i);
      wr(2'h0, 16'h0040);
      wait_idle();
      frc(10'h103, 1'b0, 16'h1111, "block word");
      frc(10'h104, 1'b0, 16'h2222, "block word");
      wr(2'h0, 16'h0040);
      fw(10'h102, 16'h0000, 2'h3, 1'b0);
      repeat (8) @(posedge clk_sys_i);
      stop <= 1'b1;
      wait_idle();
      chk("busy", 16'h0000, {15'h0, busy_o});
      rdc(2'h2, 16'h0081, 16'h0080, "fail");
      rdc(2'h0, 16'h00C6, 16'h0000, "mode");
      stop <= 1'b0;
      tally_and_finish();
   end
endmodule // tb_flash_erase_write_controller
